// ==== hdl/mixvol_pkg.sv ====
// constants for the mixer gain and headphone volume register slice
package mixvol_pkg;
  // register offsets on the control interface
  localparam logic [7:0] ADDR_REC_MIX = 8'h63;
  localparam logic [7:0] ADDR_RETURN = 8'h64;
  localparam logic [7:0] ADDR_HP_LEFT = 8'h68;
  localparam logic [7:0] ADDR_HP_RIGHT = 8'h69;

  // right record mixer fields
  localparam int THIRD_GAIN_LSB = 13;
  localparam int SECOND_GAIN_LSB = 5;
  localparam int BOOST_BIT = 0;

  // return path fields
  localparam int DEST_BIT = 15;
  localparam int RET_GAIN_LSB = 1;

  // headphone channel fields
  localparam int ENABLE_BIT = 15;
  localparam int MUTE_BIT = 14;
  localparam int ZC_BIT = 13;
  localparam int COMMIT_BIT = 8;
  localparam int VOL_LSB = 2;

  // widths
  localparam int GAIN_W = 3;
  localparam int VOL_W = 6;
  localparam int REG_W = 16;

  // values after reset
  localparam logic [2:0] GAIN_OFF = 3'h0;
  localparam logic [5:0] VOL_ZERO_DB = 6'h39;
  localparam logic [15:0] RDATA_RESET = 16'h0000;

  // zero-cross applier states
  typedef enum logic [1:0] {
    ZC_IDLE = 2'b01,
    ZC_WAIT = 2'b10
  } zc_state_e;
endpackage

// ==== hdl/vol_applier.sv ====
// one headphone channel: active volume, applied at once or at a zero crossing
`timescale 1ns/1ps
module vol_applier (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // commit request and mode
  input wire logic commit,
  input wire logic zc_mode,
  input wire logic zc_det,
  input wire logic [5:0] new_vol,
  // applied gain
  output logic [5:0] active_vol,
  output logic pending
);
  typedef struct packed {
    mixvol_pkg::zc_state_e st;
    logic [5:0] pend_vol;
    logic [5:0] act_vol;
  } app_s;

  app_s s_r;
  app_s s_nxt;

  always_comb begin
    s_nxt = s_r;
    case (s_r.st)
      mixvol_pkg::ZC_IDLE: begin
        if (commit && !zc_mode) begin
          s_nxt.act_vol = new_vol;
        end else if (commit) begin
          s_nxt.pend_vol = new_vol;
          s_nxt.st = mixvol_pkg::ZC_WAIT;
        end
      end
      mixvol_pkg::ZC_WAIT: begin
        // a fresh commit replaces the held value; mode cleared releases it at once
        if (commit && !zc_mode) begin
          s_nxt.act_vol = new_vol;
          s_nxt.st = mixvol_pkg::ZC_IDLE;
        end else if (commit) begin
          s_nxt.pend_vol = new_vol;
        end else if (zc_det || !zc_mode) begin
          s_nxt.act_vol = s_r.pend_vol;
          s_nxt.st = mixvol_pkg::ZC_IDLE;
        end
      end
      default: begin
        s_nxt.st = mixvol_pkg::ZC_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_r.st <= mixvol_pkg::ZC_IDLE;
      s_r.pend_vol <= mixvol_pkg::VOL_ZERO_DB;
      s_r.act_vol <= mixvol_pkg::VOL_ZERO_DB;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign active_vol = s_r.act_vol;
  assign pending = (s_r.st == mixvol_pkg::ZC_WAIT);

  a_zc_deferred: assert property (@(posedge clk) disable iff (rst)
    commit && zc_mode && !zc_det |=> pending && $stable(active_vol))
    else $error("zero-cross commit applied before a crossing");

  a_zc_release: assert property (@(posedge clk) disable iff (rst)
    pending && zc_det && zc_mode && !commit |=> !pending && active_vol == $past(s_r.pend_vol))
    else $error("held volume not applied at zero crossing");

  a_immediate_apply: assert property (@(posedge clk) disable iff (rst)
    commit && !zc_mode |=> active_vol == $past(new_vol) && !pending)
    else $error("immediate commit did not apply");
endmodule

// ==== hdl/mixer_volume_regs.sv ====
// register slice for right record mixer, return path and first headphone pair
`timescale 1ns/1ps
module mixer_volume_regs (
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic SYS_RST,
  // control interface register port
  input wire logic [7:0] REG_ADDR,
  input wire logic [15:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [15:0] REG_RDATA,
  // record mixer and return path controls
  output logic [2:0] THIRD_RIGHT_IN_RECORD_GAIN,
  output logic [2:0] SECOND_RIGHT_IN_RECORD_GAIN,
  output logic RIGHT_PREAMP_BOOST,
  output logic RETURN_PATH_DEST_SELECT,
  output logic [2:0] RETURN_PATH_GAIN,
  // zero-cross detectors from the analogue outputs
  input wire logic HP_LEFT_ZC_DET,
  input wire logic HP_RIGHT_ZC_DET,
  // headphone left
  output logic HP_LEFT_ENABLE,
  output logic HP_LEFT_MUTE,
  output logic HP_LEFT_ZERO_CROSS,
  output logic [5:0] HP_LEFT_VOLUME,
  output logic HP_LEFT_VOL_PENDING,
  // headphone right
  output logic HP_RIGHT_ENABLE,
  output logic HP_RIGHT_MUTE,
  output logic HP_RIGHT_ZERO_CROSS,
  output logic [5:0] HP_RIGHT_VOLUME,
  output logic HP_RIGHT_VOL_PENDING
);
  typedef struct packed {
    logic [2:0] third_gain;
    logic [2:0] second_gain;
    logic boost;
    logic dest;
    logic [2:0] ret_gain;
    logic l_en;
    logic l_mute;
    logic l_zc;
    logic [5:0] l_vol;
    logic r_en;
    logic r_mute;
    logic r_zc;
    logic [5:0] r_vol;
    logic [15:0] rdata;
  } regs_s;

  regs_s st_r;
  regs_s st_nxt;
  logic wr_rec;
  logic wr_ret;
  logic wr_left;
  logic wr_right;
  logic commit;

  assign wr_rec = REG_WR && (REG_ADDR == mixvol_pkg::ADDR_REC_MIX);
  assign wr_ret = REG_WR && (REG_ADDR == mixvol_pkg::ADDR_RETURN);
  assign wr_left = REG_WR && (REG_ADDR == mixvol_pkg::ADDR_HP_LEFT);
  assign wr_right = REG_WR && (REG_ADDR == mixvol_pkg::ADDR_HP_RIGHT);
  // either channel register carries the shared update bit
  assign commit = (wr_left || wr_right) && REG_WDATA[mixvol_pkg::COMMIT_BIT];

  always_comb begin
    st_nxt = st_r;
    if (wr_rec) begin
      st_nxt.third_gain = REG_WDATA[mixvol_pkg::THIRD_GAIN_LSB +: mixvol_pkg::GAIN_W];
      st_nxt.second_gain = REG_WDATA[mixvol_pkg::SECOND_GAIN_LSB +: mixvol_pkg::GAIN_W];
      st_nxt.boost = REG_WDATA[mixvol_pkg::BOOST_BIT];
    end
    if (wr_ret) begin
      st_nxt.dest = REG_WDATA[mixvol_pkg::DEST_BIT];
      st_nxt.ret_gain = REG_WDATA[mixvol_pkg::RET_GAIN_LSB +: mixvol_pkg::GAIN_W];
    end
    if (wr_left) begin
      st_nxt.l_en = REG_WDATA[mixvol_pkg::ENABLE_BIT];
      st_nxt.l_mute = REG_WDATA[mixvol_pkg::MUTE_BIT];
      st_nxt.l_zc = REG_WDATA[mixvol_pkg::ZC_BIT];
      st_nxt.l_vol = REG_WDATA[mixvol_pkg::VOL_LSB +: mixvol_pkg::VOL_W];
    end
    if (wr_right) begin
      st_nxt.r_en = REG_WDATA[mixvol_pkg::ENABLE_BIT];
      st_nxt.r_mute = REG_WDATA[mixvol_pkg::MUTE_BIT];
      st_nxt.r_zc = REG_WDATA[mixvol_pkg::ZC_BIT];
      st_nxt.r_vol = REG_WDATA[mixvol_pkg::VOL_LSB +: mixvol_pkg::VOL_W];
    end
    // reads return the shadow volume; the update bit is a strobe and reads 0
    if (REG_RD) begin
      case (REG_ADDR)
        mixvol_pkg::ADDR_REC_MIX: begin
          st_nxt.rdata = {st_r.third_gain, 5'h00, st_r.second_gain, 4'h0, st_r.boost};
        end
        mixvol_pkg::ADDR_RETURN: begin
          st_nxt.rdata = {st_r.dest, 11'h000, st_r.ret_gain, 1'b0};
        end
        mixvol_pkg::ADDR_HP_LEFT: begin
          st_nxt.rdata = {st_r.l_en, st_r.l_mute, st_r.l_zc, 5'h00, st_r.l_vol, 2'h0};
        end
        mixvol_pkg::ADDR_HP_RIGHT: begin
          st_nxt.rdata = {st_r.r_en, st_r.r_mute, st_r.r_zc, 5'h00, st_r.r_vol, 2'h0};
        end
        default: begin
          st_nxt.rdata = mixvol_pkg::RDATA_RESET;
        end
      endcase
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      st_r.third_gain <= mixvol_pkg::GAIN_OFF;
      st_r.second_gain <= mixvol_pkg::GAIN_OFF;
      st_r.boost <= 1'b0;
      st_r.dest <= 1'b0;
      st_r.ret_gain <= mixvol_pkg::GAIN_OFF;
      st_r.l_en <= 1'b0;
      st_r.l_mute <= 1'b0;
      st_r.l_zc <= 1'b0;
      st_r.l_vol <= mixvol_pkg::VOL_ZERO_DB;
      st_r.r_en <= 1'b0;
      st_r.r_mute <= 1'b0;
      st_r.r_zc <= 1'b0;
      st_r.r_vol <= mixvol_pkg::VOL_ZERO_DB;
      st_r.rdata <= mixvol_pkg::RDATA_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  // the commit takes the value of the write that carries it, and the zero-cross
  // mode of that same write, so one write both sets and commits
  vol_applier u_left (
    .clk(CORE_CLK),
    .rst(SYS_RST),
    .commit(commit),
    .zc_mode(st_nxt.l_zc),
    .zc_det(HP_LEFT_ZC_DET),
    .new_vol(st_nxt.l_vol),
    .active_vol(HP_LEFT_VOLUME),
    .pending(HP_LEFT_VOL_PENDING)
  );

  vol_applier u_right (
    .clk(CORE_CLK),
    .rst(SYS_RST),
    .commit(commit),
    .zc_mode(st_nxt.r_zc),
    .zc_det(HP_RIGHT_ZC_DET),
    .new_vol(st_nxt.r_vol),
    .active_vol(HP_RIGHT_VOLUME),
    .pending(HP_RIGHT_VOL_PENDING)
  );

  assign REG_RDATA = st_r.rdata;
  assign THIRD_RIGHT_IN_RECORD_GAIN = st_r.third_gain;
  assign SECOND_RIGHT_IN_RECORD_GAIN = st_r.second_gain;
  assign RIGHT_PREAMP_BOOST = st_r.boost;
  assign RETURN_PATH_DEST_SELECT = st_r.dest;
  assign RETURN_PATH_GAIN = st_r.ret_gain;
  assign HP_LEFT_ENABLE = st_r.l_en;
  assign HP_LEFT_MUTE = st_r.l_mute;
  assign HP_LEFT_ZERO_CROSS = st_r.l_zc;
  assign HP_RIGHT_ENABLE = st_r.r_en;
  assign HP_RIGHT_MUTE = st_r.r_mute;
  assign HP_RIGHT_ZERO_CROSS = st_r.r_zc;

  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (SYS_RST);

  a_third_gain: assert property (wr_rec |=>
    THIRD_RIGHT_IN_RECORD_GAIN == $past(REG_WDATA[15:13]))
    else $error("third input gain not taken from write");

  a_second_gain: assert property (wr_rec |=>
    SECOND_RIGHT_IN_RECORD_GAIN == $past(REG_WDATA[7:5]))
    else $error("second input gain not taken from write");

  a_boost_bit: assert property (wr_rec |=>
    RIGHT_PREAMP_BOOST == $past(REG_WDATA[0]))
    else $error("preamp boost not taken from bit 0");

  a_return_dest: assert property (wr_ret |=>
    RETURN_PATH_DEST_SELECT == $past(REG_WDATA[15]))
    else $error("return destination not taken from bit 15");

  a_return_gain: assert property (!wr_ret |=> $stable(RETURN_PATH_GAIN)
    and $stable(RETURN_PATH_DEST_SELECT))
    else $error("return path changed without a write");

  a_enable_mute: assert property (wr_right |=>
    HP_RIGHT_ENABLE == $past(REG_WDATA[15]) && HP_RIGHT_MUTE == $past(REG_WDATA[14]))
    else $error("right enable or mute not taken from write");

  a_zc_mode: assert property (wr_left |=>
    HP_LEFT_ZERO_CROSS == $past(REG_WDATA[13]))
    else $error("left zero-cross mode not taken from bit 13");

  a_vol_held: assert property (!commit && !HP_LEFT_VOL_PENDING |=>
    $stable(HP_LEFT_VOLUME))
    else $error("left volume moved without an update");

  a_commit_pair: assert property (wr_right && REG_WDATA[8] && !REG_WDATA[13]
    && !st_r.l_zc |=> HP_RIGHT_VOLUME == $past(REG_WDATA[7:2])
    && HP_LEFT_VOLUME == st_r.l_vol)
    else $error("update did not commit both channels together");

  a_shadow_read: assert property (REG_RD && REG_ADDR == mixvol_pkg::ADDR_HP_LEFT
    && !wr_left |=> REG_RDATA[7:2] == st_r.l_vol && REG_RDATA[8] == 1'b0)
    else $error("left shadow volume not read back");

  // remaining field captures, holds, read-back layout, the left-write commit and the zero-cross wait, channel by channel
  a_return_value: assert property (wr_ret |=>
    RETURN_PATH_GAIN == $past(REG_WDATA[3:1]))
    else $error("return gain not taken from bits 3 to 1");

  a_left_enable: assert property (wr_left |=>
    HP_LEFT_ENABLE == $past(REG_WDATA[15]) && HP_LEFT_MUTE == $past(REG_WDATA[14]))
    else $error("left enable or mute not taken from write");

  a_right_zc: assert property (wr_right |=>
    HP_RIGHT_ZERO_CROSS == $past(REG_WDATA[13]))
    else $error("right zero-cross mode not taken from bit 13");

  a_right_held: assert property (!commit && !HP_RIGHT_VOL_PENDING |=>
    $stable(HP_RIGHT_VOLUME))
    else $error("right volume moved without an update");

  a_record_hold: assert property (!wr_rec |=> $stable(THIRD_RIGHT_IN_RECORD_GAIN)
    && $stable(SECOND_RIGHT_IN_RECORD_GAIN) && $stable(RIGHT_PREAMP_BOOST))
    else $error("record mixer changed without a write");

  a_left_hold: assert property (!wr_left |=> $stable(HP_LEFT_ENABLE)
    && $stable(HP_LEFT_MUTE) && $stable(HP_LEFT_ZERO_CROSS))
    else $error("left channel controls changed without a write");

  a_right_hold: assert property (!wr_right |=> $stable(HP_RIGHT_ENABLE)
    && $stable(HP_RIGHT_MUTE) && $stable(HP_RIGHT_ZERO_CROSS))
    else $error("right channel controls changed without a write");

  a_commit_left: assert property (wr_left && REG_WDATA[8] && !REG_WDATA[13]
    && !st_r.r_zc |=> HP_LEFT_VOLUME == $past(REG_WDATA[7:2])
    && HP_RIGHT_VOLUME == st_r.r_vol)
    else $error("left update did not commit both channels together");

  a_right_read: assert property (REG_RD && REG_ADDR == mixvol_pkg::ADDR_HP_RIGHT
    && !wr_right |=> REG_RDATA[7:2] == st_r.r_vol && REG_RDATA[8] == 1'b0)
    else $error("right shadow volume not read back");

  a_record_read: assert property (REG_RD && REG_ADDR == mixvol_pkg::ADDR_REC_MIX
    && !wr_rec |=> REG_RDATA[15:13] == THIRD_RIGHT_IN_RECORD_GAIN
    && REG_RDATA[7:5] == SECOND_RIGHT_IN_RECORD_GAIN && REG_RDATA[0] == RIGHT_PREAMP_BOOST
    && REG_RDATA[12:8] == 5'h00 && REG_RDATA[4:1] == 4'h0)
    else $error("record mixer fields read back out of place");

  a_return_read: assert property (REG_RD && REG_ADDR == mixvol_pkg::ADDR_RETURN
    && !wr_ret |=> REG_RDATA[15] == RETURN_PATH_DEST_SELECT
    && REG_RDATA[3:1] == RETURN_PATH_GAIN && REG_RDATA[14:4] == 11'h000)
    else $error("return path fields read back out of place");

  a_read_hold: assert property (!REG_RD |=> $stable(REG_RDATA))
    else $error("read data changed without a read");

  a_left_mode: assert property (HP_LEFT_VOL_PENDING |-> HP_LEFT_ZERO_CROSS)
    else $error("left volume held while zero-cross mode is off");

  a_right_mode: assert property (HP_RIGHT_VOL_PENDING |-> HP_RIGHT_ZERO_CROSS)
    else $error("right volume held while zero-cross mode is off");

  a_left_no_wait: assert property (!commit && !HP_LEFT_VOL_PENDING |=>
    !HP_LEFT_VOL_PENDING)
    else $error("left volume held without an update");

  a_right_no_wait: assert property (!commit && !HP_RIGHT_VOL_PENDING |=>
    !HP_RIGHT_VOL_PENDING)
    else $error("right volume held without an update");

  a_left_release: assert property (HP_LEFT_VOL_PENDING && HP_LEFT_ZC_DET
    && !commit |=> !HP_LEFT_VOL_PENDING)
    else $error("left held volume missed a zero crossing");

  a_right_release: assert property (HP_RIGHT_VOL_PENDING && HP_RIGHT_ZC_DET
    && !commit |=> !HP_RIGHT_VOL_PENDING)
    else $error("right held volume missed a zero crossing");

  a_mode_clear: assert property (HP_LEFT_VOL_PENDING && wr_left && !REG_WDATA[13]
    && !commit |=> !HP_LEFT_VOL_PENDING)
    else $error("clearing left zero-cross mode did not release the volume");

  c_commit_now: cover property (commit && !st_nxt.l_zc ##1 HP_LEFT_VOLUME != $past(HP_LEFT_VOLUME));
  c_commit_zc: cover property (HP_RIGHT_VOL_PENDING ##[1:20] !HP_RIGHT_VOL_PENDING);
  c_boost_on: cover property (wr_rec && REG_WDATA[0]);
  c_dest_right: cover property (wr_ret && REG_WDATA[15]);
  c_mode_clear: cover property (HP_LEFT_VOL_PENDING && wr_left && !REG_WDATA[13]);
endmodule

// ==== testbench/mixer_and_output_volume_regs_bench.sv ====
// self-checking bench for the mixer gain and headphone volume register slice
`timescale 1ns/1ps
module mixer_and_output_volume_regs_bench;
  logic clk, rst, wr, rd, zl, zr, boost, dest, le, lm, lz, lp, re, rm, rz, rp;
  logic [7:0] addr;
  logic [15:0] wdata, rdata, rv;
  logic [2:0] g3, g2, rg;
  logic [5:0] lv, rvol;
  int n_mismatch, compares, cyc;

  mixer_volume_regs mixer_volume_regs_i (
    .CORE_CLK(clk), .SYS_RST(rst), .REG_ADDR(addr), .REG_WDATA(wdata),
    .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata),
    .THIRD_RIGHT_IN_RECORD_GAIN(g3), .SECOND_RIGHT_IN_RECORD_GAIN(g2),
    .RIGHT_PREAMP_BOOST(boost), .RETURN_PATH_DEST_SELECT(dest), .RETURN_PATH_GAIN(rg),
    .HP_LEFT_ZC_DET(zl), .HP_RIGHT_ZC_DET(zr),
    .HP_LEFT_ENABLE(le), .HP_LEFT_MUTE(lm), .HP_LEFT_ZERO_CROSS(lz),
    .HP_LEFT_VOLUME(lv), .HP_LEFT_VOL_PENDING(lp),
    .HP_RIGHT_ENABLE(re), .HP_RIGHT_MUTE(rm), .HP_RIGHT_ZERO_CROSS(rz),
    .HP_RIGHT_VOLUME(rvol), .HP_RIGHT_VOL_PENDING(rp)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // strobes are single-cycle; the edge between the two falling edges takes them
  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a);
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    rv = rdata;
  endtask

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic t_reset;
    chk(16'({g3, g2, boost, dest, rg}), 16'h0000);
    chk(16'({le, lm, lz, re, rm, rz, lp, rp}), 16'h0000);
    chk(16'({lv, rvol}), 16'({mixvol_pkg::VOL_ZERO_DB, mixvol_pkg::VOL_ZERO_DB}));
    rd_reg(mixvol_pkg::ADDR_HP_LEFT);
    chk(rv, 16'h00e4);
    rd_reg(mixvol_pkg::ADDR_HP_RIGHT);
    chk(rv, 16'h00e4);
    rd_reg(mixvol_pkg::ADDR_REC_MIX);
    chk(rv, 16'h0000);
    rd_reg(8'h70);
    chk(rv, 16'h0000);
    $display("test reset done");
  endtask

  task automatic t_record;
    logic [2:0] g;
    logic [2:0] h;
    for (int i = 0; i < 8; i++) begin
      g = i[2:0];
      h = ~g;
      // reserved bits written as ones must not leak into the fields
      wr_reg(mixvol_pkg::ADDR_REC_MIX, {g, 5'h1f, h, 4'hf, g[0]});
      chk(16'({g3, g2, boost}), 16'({g, h, g[0]}));
      rd_reg(mixvol_pkg::ADDR_REC_MIX);
      chk(rv, {g, 5'h00, h, 4'h0, g[0]});
    end
    $display("test record mixer done");
  endtask

  task automatic t_return;
    logic [2:0] g;
    for (int i = 0; i < 8; i++) begin
      g = i[2:0];
      wr_reg(mixvol_pkg::ADDR_RETURN, {~g[0], 11'h7ff, g, 1'b1});
      chk(16'({dest, rg}), 16'({~g[0], g}));
      rd_reg(mixvol_pkg::ADDR_RETURN);
      chk(rv, {~g[0], 11'h000, g, 1'b0});
    end
    $display("test return path done");
  endtask

  task automatic t_commit;
    wr_reg(mixvol_pkg::ADDR_HP_LEFT, 16'hc040);
    chk(16'({le, lm, lz}), 16'h0006);
    chk(16'(lv), 16'h0039);
    rd_reg(mixvol_pkg::ADDR_HP_LEFT);
    chk(rv, 16'hc040);
    wr_reg(mixvol_pkg::ADDR_HP_RIGHT, 16'h8180);
    chk(16'({lv, rvol}), 16'h0420);
    chk(16'({re, rm, rz}), 16'h0004);
    rd_reg(mixvol_pkg::ADDR_HP_RIGHT);
    chk(rv, 16'h8080);
    wr_reg(mixvol_pkg::ADDR_HP_LEFT, 16'h0100);
    chk(16'({le, lm, lv, rvol}), 16'h0020);
    wr_reg(mixvol_pkg::ADDR_HP_RIGHT, 16'h00fc);
    chk(16'(rvol), 16'h0020);
    wr_reg(mixvol_pkg::ADDR_HP_LEFT, 16'h0100);
    chk(16'(rvol), 16'h003f);
    $display("test volume commit done");
  endtask

  task automatic t_zero_cross;
    wr_reg(mixvol_pkg::ADDR_HP_LEFT, 16'h2124);
    repeat (3) @(negedge clk);
    chk(16'({lz, lp, lv}), 16'h00c0);
    @(negedge clk);
    zl = 1'b1;
    @(negedge clk);
    zl = 1'b0;
    for (int k = 0; k < 3 && lp === 1'b1; k++) @(negedge clk);
    chk(16'({lp, lv}), 16'h0009);
    wr_reg(mixvol_pkg::ADDR_HP_RIGHT, 16'h2114);
    chk(16'({rz, rp, rvol}), 16'h00ff);
    @(negedge clk);
    zr = 1'b1;
    @(negedge clk);
    zr = 1'b0;
    for (int k = 0; k < 3 && rp === 1'b1; k++) @(negedge clk);
    chk(16'({rp, rvol}), 16'h0005);
    // a new commit in zero-cross mode is held; clearing the mode without a crossing releases it
    wr_reg(mixvol_pkg::ADDR_HP_LEFT, 16'h2130);
    chk(16'({lp, lv}), 16'h0049);
    wr_reg(mixvol_pkg::ADDR_HP_LEFT, 16'h0030);
    chk(16'({lz, lp, lv}), 16'h000c);
    $display("test zero cross done");
  endtask

  // runaway guard, well above the hundred or so cycles the tests need
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      close_out;
    end
  end

  initial begin
    rst = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    zl = 1'b0;
    zr = 1'b0;
    addr = 8'h00;
    wdata = 16'h0000;
    repeat (12) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    t_reset;
    t_record;
    t_return;
    t_commit;
    t_zero_cross;
    close_out;
  end
endmodule
